// ---- rtl/p3c_pin_cell.sv ----
// Purpose: output value and enable of one port 3 pin
// Assumes: alternate source chosen by the function select bit
// Notes:   open-drain drives only low; high is left to the pull-up
`timescale 1ns/100ps
module p3c_pin_cell (
  // port side
  input  wire logic latch,
  input  wire logic dir_in,
  input  wire logic od_port,
  // alternate side
  input  wire logic alt_sel,
  input  wire logic alt_drive,
  input  wire logic alt_val,
  input  wire logic od_alt,
  // pin
  output logic      pin_out,
  output logic      pin_oe
);

  logic val;
  logic en;
  logic od;

  // ==========================================================================
  // source selection and drive
  always_comb begin
    if (alt_sel) begin
      val = alt_val;                             // R18
      en  = alt_drive;                           // R18
      od  = od_alt;
    end else begin
      val = latch;                               // R05
      en  = ~dir_in;                             // R04
      od  = od_port;
    end
    pin_out = od ? 1'b0 : val;
    pin_oe  = en & (od ? ~val : 1'b1);
  end

endmodule

// ---- rtl/p3c_pkg.sv ----
// Purpose: constants and state layout of the port 3 pin control block
// Assumes: AXI4-Lite with 32-bit data, 16-bit byte address
// Notes:   register index times four gives the byte address
package p3c_pkg;

  // ==========================================================================
  // register indices and byte addresses
  localparam int unsigned P3C_AW = 16;
  localparam logic [31:0] P3C_IDX_LATCH   = 32'hFFFF_F406;
  localparam logic [31:0] P3C_IDX_LATCH_H = 32'hFFFF_F407;
  localparam logic [31:0] P3C_IDX_DIR     = 32'hFFFF_F426;
  localparam logic [31:0] P3C_IDX_DIR_H   = 32'hFFFF_F427;
  localparam logic [31:0] P3C_IDX_FSEL    = 32'hFFFF_F446;
  localparam logic [31:0] P3C_IDX_FSEL_H  = 32'hFFFF_F447;
  localparam logic [31:0] P3C_IDX_TROLE   = 32'hFFFF_F466;
  localparam logic [31:0] P3C_IDX_OD      = 32'hFFFF_F468;
  localparam logic [31:0] P3C_IDX_PU      = 32'hFFFF_FC46;
  localparam logic [15:0] P3C_A_LATCH   = {P3C_IDX_LATCH[13:0], 2'b00};
  localparam logic [15:0] P3C_A_LATCH_H = {P3C_IDX_LATCH_H[13:0], 2'b00};
  localparam logic [15:0] P3C_A_DIR     = {P3C_IDX_DIR[13:0], 2'b00};
  localparam logic [15:0] P3C_A_DIR_H   = {P3C_IDX_DIR_H[13:0], 2'b00};
  localparam logic [15:0] P3C_A_FSEL    = {P3C_IDX_FSEL[13:0], 2'b00};
  localparam logic [15:0] P3C_A_FSEL_H  = {P3C_IDX_FSEL_H[13:0], 2'b00};
  localparam logic [15:0] P3C_A_TROLE   = {P3C_IDX_TROLE[13:0], 2'b00};
  localparam logic [15:0] P3C_A_OD      = {P3C_IDX_OD[13:0], 2'b00};
  localparam logic [15:0] P3C_A_PU      = {P3C_IDX_PU[13:0], 2'b00};

  // ==========================================================================
  // implemented bits, reset values, field positions
  localparam logic [15:0] P3C_IMPL_LARGE = 16'h03FF;
  localparam logic [15:0] P3C_IMPL_SMALL = 16'h033F;
  localparam logic [15:0] P3C_FSEL_MASK  = 16'h033F;
  localparam logic [7:0]  P3C_TROLE_MASK = 8'h28;
  localparam logic [7:0]  P3C_OD_MASK    = 8'h03;
  localparam logic [7:0]  P3C_PU_MASK    = 8'h3F;
  localparam logic [15:0] P3C_RST_LATCH  = 16'h0000;
  localparam logic [15:0] P3C_RST_DIR    = 16'hFFFF;
  localparam logic [15:0] P3C_RST_FSEL   = 16'h0000;
  localparam logic [7:0]  P3C_RST_8      = 8'h00;
  localparam int unsigned P3C_NPIN       = 10;
  localparam int unsigned P3C_TROLE_A    = 3;
  localparam int unsigned P3C_TROLE_C    = 5;
  localparam logic [1:0]  P3C_OKAY       = 2'b00;
  localparam logic [1:0]  P3C_SLVERR     = 2'b10;

  // ==========================================================================
  // whole state of the block
  typedef struct packed {
    logic [15:0]       latch;
    logic [15:0]       dir;
    logic [15:0]       fsel;
    logic [7:0]        trole;
    logic [7:0]        od;
    logic [7:0]        pu;
    logic              aw_held;
    logic [P3C_AW-1:0] aw_addr;
    logic              w_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } p3c_state_s;

endpackage

// ---- rtl/p3c_port_top.sv ----
// Purpose: port 3 pin control with AXI4-Lite register access
// Assumes: pin inputs synchronous to aclk; one write and one read at a time
// Notes:   LARGE_VARIANT selects pins 0-9, else pins 0-5, 8, 9
`timescale 1ns/100ps
// Function
// R01: data register 16-bit, byte aliases allow bytes
// R02: full and low alias lower, high next
// R03: high alias bits map register bits 8-15
// R04: input pin reads live level, writes latch
// R05: output pin reads latch, drives written value
// R06: implemented bits per variant, others constant
// R07: direction resets ones, 0 output, 1 input
// R08: function select chooses port or peripheral
// R09: function select resets zero, high alias
// R10: software keeps pins 6,7 select zero
// R11: open-drain register for pins 8 and 9
// R12: software sets latch, open-drain, then select
// R13: timer role register resets zero, own address
// R14: role bit 5: pin 5 capture or compare
// R15: role bit 3: pin 3 capture or compare
// R16: software writes zero to unused role bits
// R17: pull-up register resets zero, bits 0-5
// R18: alternate mode routes peripheral to pin
module p3c_port_top #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // axi write address
  input  wire logic [p3c_pkg::P3C_AW-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  // axi write data
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // axi write response
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // axi read address
  input  wire logic [p3c_pkg::P3C_AW-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  // axi read data
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // pins
  input  wire logic [9:0]                 pin_in,
  output logic      [9:0]                 pin_out,
  output logic      [9:0]                 pin_oe,
  output logic      [5:0]                 pullup_en,
  // peripheral outputs toward the pins
  input  wire logic                       uart_transmit_out,
  input  wire logic                       timer_compare_out_a,
  input  wire logic                       timer_compare_out_c,
  input  wire logic                       twowire_data_line_drive,
  input  wire logic                       twowire_clock_line_drive,
  // pin levels toward the peripherals
  output logic                            uart_receive_in,
  output logic                            uart_serial_clock_in,
  output logic                            timer_capture_in_a,
  output logic                            timer_capture_in_b,
  output logic                            timer_capture_in_c,
  output logic                            twowire_data_line_in,
  output logic                            twowire_clock_line_in
);

  // ==========================================================================
  // parameter check
  if (LARGE_VARIANT !== 1'b0 && LARGE_VARIANT !== 1'b1) begin : g_bad_variant
    $error("LARGE_VARIANT must be 0 or 1");
  end

  localparam logic [15:0] IMPL = LARGE_VARIANT ? p3c_pkg::P3C_IMPL_LARGE
                                               : p3c_pkg::P3C_IMPL_SMALL; // R06

  p3c_pkg::p3c_state_s s_ff;
  p3c_pkg::p3c_state_s nxt_s;

  // ==========================================================================
  // helpers
  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [15:0] d,
                                       input logic [1:0] sel, input logic [15:0] mask);
    logic [15:0] m;
    m = mask & {{8{sel[1]}}, {8{sel[0]}}};
    wr16 = (old & ~m) | (d & m);
  endfunction

  function automatic logic [7:0] wr8(input logic [7:0] old, input logic [7:0] d,
                                     input logic en, input logic [7:0] mask);
    logic [7:0] m;
    m = en ? mask : 8'h00;
    wr8 = (old & ~m) | (d & m);
  endfunction

  localparam int unsigned P3C_AWL = p3c_pkg::P3C_AW;

  logic [15:0] pin_in_w;
  assign pin_in_w = {6'h00, pin_in};

  logic [15:0] data_view;
  logic [15:0] dir_view;
  logic [15:0] fsel_view;

  always_comb begin
    data_view = ((s_ff.dir & pin_in_w) | (~s_ff.dir & s_ff.latch)) & IMPL; // R04 R05 R06
    dir_view  = s_ff.dir | ~IMPL;                                          // R06 R07
    fsel_view = s_ff.fsel & p3c_pkg::P3C_FSEL_MASK & IMPL;
  end

  // ==========================================================================
  // handshakes
  assign s_axi_awready = ~s_ff.aw_held & ~s_ff.bvalid;
  assign s_axi_wready  = ~s_ff.w_held & ~s_ff.bvalid;
  assign s_axi_arready = ~s_ff.rvalid;
  assign s_axi_bvalid  = s_ff.bvalid;
  assign s_axi_bresp   = s_ff.bresp;
  assign s_axi_rvalid  = s_ff.rvalid;
  assign s_axi_rdata   = s_ff.rdata;
  assign s_axi_rresp   = s_ff.rresp;

  // ==========================================================================
  // next state
  always_comb begin
    logic [15:0] d16;
    logic [15:0] dh;
    logic [1:0]  sel;
    logic [1:0]  selh;
    logic        ok16;
    logic [P3C_AWL-1:0] ra;
    nxt_s = s_ff;
    d16   = s_axi_wdata[15:0];
    dh    = 16'h0000;
    sel   = 2'b00;
    selh  = 2'b00;
    ok16  = 1'b0;
    ra    = s_axi_araddr;
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_s.aw_held = 1'b1;
      nxt_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_s.w_held = 1'b1;
      nxt_s.w_data = s_axi_wdata;
      nxt_s.w_strb = s_axi_wstrb;
    end
    if (s_ff.aw_held && s_ff.w_held && !s_ff.bvalid) begin
      d16  = s_ff.w_data[15:0];
      dh   = {s_ff.w_data[7:0], 8'h00};                          // R03
      sel  = s_ff.w_strb[1:0];
      selh = {s_ff.w_strb[0], 1'b0};                             // R03
      ok16 = (sel != 2'b10);                                     // R01
      nxt_s.aw_held = 1'b0;
      nxt_s.w_held  = 1'b0;
      nxt_s.bvalid  = 1'b1;
      nxt_s.bresp   = p3c_pkg::P3C_OKAY;
      if (s_ff.aw_addr == p3c_pkg::P3C_A_LATCH && ok16) begin   // R02
        nxt_s.latch = wr16(s_ff.latch, d16, sel, IMPL);          // R01 R04 R05
      end else if (s_ff.aw_addr == p3c_pkg::P3C_A_LATCH_H) begin
        nxt_s.latch = wr16(s_ff.latch, dh, selh, IMPL);          // R02 R03
      end else if (s_ff.aw_addr == p3c_pkg::P3C_A_DIR && ok16) begin
        nxt_s.dir = wr16(s_ff.dir, d16, sel, IMPL);              // R07
      end else if (s_ff.aw_addr == p3c_pkg::P3C_A_DIR_H) begin
        nxt_s.dir = wr16(s_ff.dir, dh, selh, IMPL);              // R07
      end else if (s_ff.aw_addr == p3c_pkg::P3C_A_FSEL && ok16) begin
        nxt_s.fsel = wr16(s_ff.fsel, d16, sel, p3c_pkg::P3C_FSEL_MASK & IMPL); // R08
      end else if (s_ff.aw_addr == p3c_pkg::P3C_A_FSEL_H) begin
        nxt_s.fsel = wr16(s_ff.fsel, dh, selh, p3c_pkg::P3C_FSEL_MASK & IMPL); // R09
      end else if (s_ff.aw_addr == p3c_pkg::P3C_A_TROLE) begin
        nxt_s.trole = wr8(s_ff.trole, s_ff.w_data[7:0], s_ff.w_strb[0],
                          p3c_pkg::P3C_TROLE_MASK);              // R13
      end else if (s_ff.aw_addr == p3c_pkg::P3C_A_OD) begin
        nxt_s.od = wr8(s_ff.od, s_ff.w_data[7:0], s_ff.w_strb[0],
                       p3c_pkg::P3C_OD_MASK);                    // R11
      end else if (s_ff.aw_addr == p3c_pkg::P3C_A_PU) begin
        nxt_s.pu = wr8(s_ff.pu, s_ff.w_data[7:0], s_ff.w_strb[0],
                       p3c_pkg::P3C_PU_MASK);                    // R17
      end else begin
        nxt_s.bresp = p3c_pkg::P3C_SLVERR;
      end
    end
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp  = p3c_pkg::P3C_OKAY;
      nxt_s.rdata  = 32'h0000_0000;
      if (ra == p3c_pkg::P3C_A_LATCH) begin
        nxt_s.rdata = {16'h0000, data_view};                     // R04 R05
      end else if (ra == p3c_pkg::P3C_A_LATCH_H) begin
        nxt_s.rdata = {24'h00_0000, data_view[15:8]};            // R03
      end else if (ra == p3c_pkg::P3C_A_DIR) begin
        nxt_s.rdata = {16'h0000, dir_view};                      // R07
      end else if (ra == p3c_pkg::P3C_A_DIR_H) begin
        nxt_s.rdata = {24'h00_0000, dir_view[15:8]};             // R03
      end else if (ra == p3c_pkg::P3C_A_FSEL) begin
        nxt_s.rdata = {16'h0000, fsel_view};
      end else if (ra == p3c_pkg::P3C_A_FSEL_H) begin
        nxt_s.rdata = {24'h00_0000, fsel_view[15:8]};            // R09
      end else if (ra == p3c_pkg::P3C_A_TROLE) begin
        nxt_s.rdata = {24'h00_0000, s_ff.trole};
      end else if (ra == p3c_pkg::P3C_A_OD) begin
        nxt_s.rdata = {24'h00_0000, s_ff.od};
      end else if (ra == p3c_pkg::P3C_A_PU) begin
        nxt_s.rdata = {24'h00_0000, s_ff.pu};
      end else begin
        nxt_s.rresp = p3c_pkg::P3C_SLVERR;
      end
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff       <= '0;
      s_ff.latch <= p3c_pkg::P3C_RST_LATCH;                      // R02
      s_ff.dir   <= p3c_pkg::P3C_RST_DIR;                        // R07
      s_ff.fsel  <= p3c_pkg::P3C_RST_FSEL;                       // R09
      s_ff.trole <= p3c_pkg::P3C_RST_8;                          // R13
      s_ff.od    <= p3c_pkg::P3C_RST_8;
      s_ff.pu    <= p3c_pkg::P3C_RST_8;                          // R17
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================================
  // per-pin alternate routing
  logic [9:0] alt_drive;
  logic [9:0] alt_val;
  logic [9:0] od_port;
  logic [9:0] od_alt;

  always_comb begin
    alt_drive = 10'h000;
    alt_val   = 10'h3FF;
    od_port   = 10'h000;
    od_alt    = 10'h000;
    alt_drive[0] = 1'b1;                                         // R08
    alt_val[0]   = uart_transmit_out;
    alt_drive[3] = s_ff.trole[p3c_pkg::P3C_TROLE_A];             // R15
    alt_val[3]   = timer_compare_out_a;
    alt_drive[5] = s_ff.trole[p3c_pkg::P3C_TROLE_C];             // R14
    alt_val[5]   = timer_compare_out_c;
    alt_drive[8] = 1'b1;
    alt_val[8]   = twowire_data_line_drive;
    alt_drive[9] = 1'b1;
    alt_val[9]   = twowire_clock_line_drive;
    od_port[6]   = LARGE_VARIANT;
    od_port[7]   = LARGE_VARIANT;
    od_port[8]   = ~s_ff.od[0];                                  // R11
    od_port[9]   = ~s_ff.od[1];                                  // R11
    od_alt[8]    = s_ff.od[0];                                   // R11 R12
    od_alt[9]    = s_ff.od[1];                                   // R11 R12
  end

  for (genvar i = 0; i < p3c_pkg::P3C_NPIN; i++) begin : g_pin
    p3c_pin_cell u_cell (
      .latch     (s_ff.latch[i] & IMPL[i]),
      .dir_in    (dir_view[i]),
      .od_port   (od_port[i]),
      .alt_sel   (fsel_view[i]),
      .alt_drive (alt_drive[i]),
      .alt_val   (alt_val[i]),
      .od_alt    (od_alt[i]),
      .pin_out   (pin_out[i]),
      .pin_oe    (pin_oe[i])
    );
  end

  // ==========================================================================
  // pin levels to peripherals, idle high when not selected
  always_comb begin
    uart_receive_in       = fsel_view[1] ? pin_in[1] : 1'b1;    // R18
    uart_serial_clock_in  = fsel_view[2] ? pin_in[2] : 1'b1;
    timer_capture_in_a    = (fsel_view[3] & ~s_ff.trole[p3c_pkg::P3C_TROLE_A])
                            ? pin_in[3] : 1'b1;                  // R15
    timer_capture_in_b    = fsel_view[4] ? pin_in[4] : 1'b1;
    timer_capture_in_c    = (fsel_view[5] & ~s_ff.trole[p3c_pkg::P3C_TROLE_C])
                            ? pin_in[5] : 1'b1;                  // R14
    twowire_data_line_in  = fsel_view[8] ? pin_in[8] : 1'b1;
    twowire_clock_line_in = fsel_view[9] ? pin_in[9] : 1'b1;
    pullup_en             = s_ff.pu[5:0];                        // R17
  end

endmodule

// ---- tb/p3c_port_properties.sv ----
// Purpose: port-level properties of the port 3 pin control block
// Assumes: bound to p3c_port_top, one clock domain
// Notes:   sees ports only
`timescale 1ns/100ps
module p3c_port_properties (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // pins
  input wire logic [9:0]  pin_in,
  input wire logic [9:0]  pin_out,
  input wire logic [9:0]  pin_oe,
  input wire logic [5:0]  pullup_en,
  input wire logic        uart_receive_in,
  input wire logic        twowire_data_line_in
);
  // ==========================================================================
  // properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reset_state_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
    && pin_oe == 10'h000 && pullup_en == 6'h00) else $error("state after reset wrong");
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data not held");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response not held");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  alt_input_a: assert property (!(!uart_receive_in && pin_in[1])
    && !(!twowire_data_line_in && pin_in[8])) else $error("peripheral input wrong");
  od_pins_a: assert property ((pin_oe[7:6] & pin_out[7:6]) == 2'b00)
    else $error("open-drain pin driven high");
  oe_change_a: assert property ($changed(pin_oe[5:0]) || $changed(pullup_en)
    |-> $rose(s_axi_bvalid)) else $error("pin control changed without write");
  cover property (s_axi_rvalid && !s_axi_rready);
  cover property (s_axi_bvalid && !s_axi_bready);
  cover property (pin_oe[3] && pin_oe[5]);
endmodule
bind p3c_port_top p3c_port_properties u_props (.*);

// ---- tb/testbench.sv ----
// Purpose: self-checking bench of the port 3 pin control block
// Assumes: large variant, random ready stalls
// Notes:   driver queues expected answers, a monitor compares them
`timescale 1ns/100ps
module testbench;
  // ==========================================================================
  // signals
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [15:0] s_axi_awaddr = 0;
  logic [15:0] s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic        s_axi_bready = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [9:0]  pin_in = 0, pin_out, pin_oe;
  logic [5:0]  pullup_en;
  logic        uart_transmit_out = 0, timer_compare_out_a = 0, timer_compare_out_c = 0;
  logic        twowire_data_line_drive = 1, twowire_clock_line_drive = 1;
  logic        uart_receive_in, uart_serial_clock_in, twowire_data_line_in;
  logic        timer_capture_in_a, timer_capture_in_b, timer_capture_in_c;
  logic        twowire_clock_line_in;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          bad_count = 0, comparisons = 0, seed = 53;
  always #2 aclk = ~aclk;
  p3c_port_top #(.LARGE_VARIANT(1'b1)) DUT (.*);
  // ==========================================================================
  // ready stalls and monitor
  always @(posedge aclk) begin
    if (!s_axi_bready || s_axi_bvalid) s_axi_bready <= 1'($random(seed));
    if (!s_axi_rready || s_axi_rvalid) s_axi_rready <= 1'($random(seed));
    if (aresetn && s_axi_bvalid && s_axi_bready) check(34'(s_axi_bresp), 34'(bq.pop_front()), "bresp");
    if (aresetn && s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front(), "read");
  end
  // ==========================================================================
  // tasks
  task automatic check(input logic [33:0] got, input logic [33:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic xfer(input bit w, input logic [15:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [33:0] e);
    logic ah, wh, rh;
    int   n;
    if (w) bq.push_back(e[33:32]);
    else rq.push_back(e);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    rh = 0;
    for (n = 0; n < 64 && !rh; n++) begin
      #1;
      ah = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
      wh = s_axi_wvalid && s_axi_wready;
      rh = w ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 0;
      if (ah) s_axi_arvalid <= 0;
      if (wh) s_axi_wvalid <= 0;
    end
    if (!rh) check(34'h0, 34'h1, "no answer");
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    xfer(1, a, d, s, {p3c_pkg::P3C_OKAY, 32'h0});
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] d);
    xfer(0, a, 32'h0, 4'h0, {p3c_pkg::P3C_OKAY, d});
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    check(34'h0, 34'h1, "watchdog");
    close_out();
  end
  // ==========================================================================
  // tests
  initial begin
    int i;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    pin_in <= 10'($random(seed));
    @(posedge aclk);
    rd(p3c_pkg::P3C_A_LATCH, 32'({6'h00, pin_in}));
    rd(p3c_pkg::P3C_A_DIR, 32'h0000_FFFF);
    rd(p3c_pkg::P3C_A_FSEL, 32'h0000_0000);
    rd(p3c_pkg::P3C_A_TROLE, 32'h0000_0000);
    rd(p3c_pkg::P3C_A_OD, 32'h0000_0000);
    rd(p3c_pkg::P3C_A_PU, 32'h0000_0000);
    $display("test reset values done");
    wr(p3c_pkg::P3C_A_LATCH, 32'h0000_03FF, 4'h3);
    rd(p3c_pkg::P3C_A_LATCH, 32'({6'h00, pin_in}));
    #1;
    check(34'(pin_oe), 34'h0, "input pins idle");
    @(posedge aclk);
    wr(p3c_pkg::P3C_A_DIR, 32'h0000_0000, 4'h3);
    rd(p3c_pkg::P3C_A_LATCH, 32'h0000_03FF);
    rd(p3c_pkg::P3C_A_DIR, 32'h0000_FC00);
    wr(p3c_pkg::P3C_A_LATCH, 32'h0000_0015, 4'h3);
    #1;
    check(34'({pin_oe[7:0], pin_out[5:0]}), 34'h3FD5, "port outputs");
    @(posedge aclk);
    $display("test direction done");
    wr(p3c_pkg::P3C_A_LATCH_H, 32'h0000_0002, 4'h1);
    wr(p3c_pkg::P3C_A_LATCH, 32'h0000_00AA, 4'h1);
    xfer(1, p3c_pkg::P3C_A_LATCH, 32'h0000_5555, 4'h2, {p3c_pkg::P3C_SLVERR, 32'h0});
    rd(p3c_pkg::P3C_A_LATCH, 32'h0000_02AA);
    rd(p3c_pkg::P3C_A_LATCH_H, 32'h0000_0002);
    wr(p3c_pkg::P3C_A_DIR_H, 32'h0000_0001, 4'h1);
    rd(p3c_pkg::P3C_A_DIR_H, 32'h0000_00FD);
    wr(p3c_pkg::P3C_A_FSEL_H, 32'h0000_00FF, 4'h1);
    rd(p3c_pkg::P3C_A_FSEL, 32'h0000_0300);
    $display("test aliases done");
    wr(p3c_pkg::P3C_A_FSEL, 32'h0000_FFFF, 4'h3);
    rd(p3c_pkg::P3C_A_FSEL, 32'h0000_033F);
    for (i = 0; i < 4; i++) begin
      pin_in <= 10'($random(seed));
      {uart_transmit_out, timer_compare_out_a, timer_compare_out_c} <= 3'($random(seed));
      if (i == 2) wr(p3c_pkg::P3C_A_TROLE, 32'h0000_0028, 4'h1);
      else @(posedge aclk);
      #1;
      check(34'({pin_oe[0], pin_out[0]}), 34'({1'b1, uart_transmit_out}), "uart out");
      check(34'({uart_receive_in, uart_serial_clock_in, timer_capture_in_b}),
            34'({pin_in[1], pin_in[2], pin_in[4]}), "alt in");
      if (i < 2) check(34'({pin_oe[3], pin_oe[5], timer_capture_in_a, timer_capture_in_c}),
                       34'({2'b00, pin_in[3], pin_in[5]}), "capture");
      else check(34'({pin_oe[3], pin_out[3], pin_oe[5], pin_out[5], timer_capture_in_a,
                 timer_capture_in_c}), 34'({1'b1, timer_compare_out_a, 1'b1,
                 timer_compare_out_c, 2'b11}), "compare");
      @(posedge aclk);
    end
    $display("test alternate done");
    wr(p3c_pkg::P3C_A_FSEL_H, 32'h0000_0000, 4'h1);
    wr(p3c_pkg::P3C_A_LATCH_H, 32'h0000_0003, 4'h1);
    wr(p3c_pkg::P3C_A_OD, 32'h0000_0003, 4'h1);
    rd(p3c_pkg::P3C_A_OD, 32'h0000_0003);
    wr(p3c_pkg::P3C_A_FSEL_H, 32'h0000_0003, 4'h1);
    for (i = 0; i < 2; i++) begin
      twowire_data_line_drive <= i[0];
      twowire_clock_line_drive <= i[0];
      pin_in <= 10'($random(seed));
      @(posedge aclk);
      #1;
      check(34'({pin_oe[9:8], pin_oe[8] & pin_out[8], pin_oe[9] & pin_out[9],
                 twowire_data_line_in, twowire_clock_line_in}),
            34'({~i[0], ~i[0], 2'b00, pin_in[8], pin_in[9]}), "two-wire");
      @(posedge aclk);
    end
    $display("test open drain done");
    wr(p3c_pkg::P3C_A_PU, 32'h0000_00FF, 4'h1);
    rd(p3c_pkg::P3C_A_PU, 32'h0000_003F);
    #1;
    check(34'(pullup_en), 34'h3F, "pull-up");
    @(posedge aclk);
    xfer(1, 16'h0004, 32'h0000_0001, 4'hF, {p3c_pkg::P3C_SLVERR, 32'h0});
    xfer(0, 16'h0004, 32'h0000_0000, 4'h0, {p3c_pkg::P3C_SLVERR, 32'h0});
    $display("test pull-up and unmapped done");
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(p3c_pkg::P3C_A_DIR, 32'h0000_FFFF);
    rd(p3c_pkg::P3C_A_FSEL, 32'h0000_0000);
    $display("test second reset done");
    repeat (2) @(posedge aclk);
    check(34'(rq.size() + bq.size()), 34'h0, "answers left over");
    close_out();
  end
endmodule
